// *** acc_id_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the accessory id block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz clock
// Notes: definitions only, included by the package users
`ifndef ACC_ID_REGS_SVH
`define ACC_ID_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define STANDBY_SAMPLE_MS 50
`define STUCK_KEY_MS 1500
`define SUPPLY_START_CYCLES 4'h8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_MODE 8'h00
`define REG_STATUS 8'h04
`define REG_ADC 8'h08
`define REG_EVENTS 8'h0c
`define REG_SWITCH 8'h10
`define REG_KEY 8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MODE_ACTIVE_BIT 0
`define MODE_RST_BIT 1
`define STATUS_RESET 5'h01
`define ADC_RESET 5'h1f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// id codes
// ----------------------------------------------------------------
`define ADC_SHORT_CODE 5'h00
`define ADC_OPEN_CODE 5'h1f
`define KEY_FIRST_CODE 5'h01
`define KEY_LAST_CODE 5'h0d
`define RC_ACC_A_CODE 5'h1d
`define RC_ACC_B_CODE 5'h1e
`define TEST_USB_A_CODE 5'h10
`define TEST_USB_B_CODE 5'h11
`define TEST_UART_A_CODE 5'h12
`define TEST_UART_B_CODE 5'h13

`endif

// *** acc_id_pkg.sv ***
// Purpose: types shared by the accessory id block
// Assumes: nothing beyond the register header
// Notes: state codes are written out
package acc_id_pkg;

   // ----------------------------------------------------------------
   // identification state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_SUPPLY = 3'b000,   // internal supplies starting
      ST_CLEAR = 3'b001,    // whole-chip clear after supply start
      ST_STANDBY = 3'b010,  // watching id line and bus power
      ST_MEASURE = 3'b011,  // adc and supply type run
      ST_ACTIVE = 3'b100,   // accessory identified
      ST_STUCK = 3'b101,    // key code seen, waiting for release
      ST_KEY_HELD = 3'b110  // stuck key reported, waiting for release
   } id_state_e;

   // status register fields, bit 4 first
   typedef struct packed {
      logic usb_chg;
      logic dpdm_short;
      logic vbus_det;
      logic id_short_flag;
      logic id_open_flag;
   } status_s;

   // sticky event flags
   typedef struct packed {
      logic detach;
      logic flag_a;
   } events_s;

   // signal switch controls
   typedef struct packed {
      logic uart;
      logic usb;
   } switch_s;

endpackage

// *** tick_gen.sv ***
// Purpose: one-cycle enable pulse every millisecond
// Assumes: single clock, synchronous active-low reset
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "acc_id_regs.svh"

module tick_gen
   import acc_id_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick_q
);

   localparam int CW = $clog2(TICK_CYCLES + 1);

   logic [CW-1:0] cnt_q; // cycles since the last pulse
   logic [CW-1:0] cnt_d;
   logic tick_d;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   // wrap the count and pulse once per period
   always_comb begin
      if (cnt_q == CW'(TICK_CYCLES - 1)) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
         tick_d = 1'b0;
      end
   end

   // register the divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   // the pulse comes exactly when the count restarts
   a_tick_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      tick_q |-> (cnt_q == '0))
      else $error("tick pulse without count restart");

endmodule // tick_gen

// *** acc_id_detect.sv ***
// Purpose: accessory detection and identification with an AXI4-Lite register port
// Assumes: all inputs synchronous to aclk; aresetn is the main-supply power-on reset
// Notes: the adc and supply-type comparators are analog; this logic sequences them
//
// Overview of operation
// - bus power at supply-up goes straight to identification
// - power-on reset clears register bits except rst, id open flag and adc result, which come up set
// - power switch stays on through reset with bus power
// - supplies start, chip clears, then standby
// - power switch off without bus power
// - bus power rising in standby starts identification
// - powered accessory latches d+ d- connection state
// - test cable codes close usb or uart switches
// - remote accessory keeps id line monitored for keys
// - standby watches id and bus power together
// - host clearing active bit restarts identification, except while a reported stuck key is held
// - id open flag follows floating id line
// - open flag falling attaches, rising detaches
// - 5-bit adc code held in result register
// - codes 1 to 13 are remote keys
// - key released within 1.5 s re-detects
// - after stuck key release, re-measure and flag_a
// - short-range resistance reports code zero
// - id short flag set for grounded id line
// - each code maps to one ascending resistance
// - floating id line reports code 11111
// - standby samples id line every 50 ms
// - results stored and flag_a flag set
`timescale 1ns/1ps
`include "acc_id_regs.svh"

module acc_id_detect
   import acc_id_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // analog front end
   input wire logic vbus_present,
   input wire logic id_open_in,
   input wire logic id_short_in,
   input wire logic dpdm_short_in,
   input wire logic usb_chg_in,
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [4:0] adc_code,
   // switch controls
   output logic power_switch_on,
   output logic usb_switch_on,
   output logic uart_switch_on
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic tick; // one millisecond enable
   id_state_e state_q, state_d;
   logic busy_q, busy_d; // adc conversion outstanding
   logic [10:0] ms_q, ms_d; // milliseconds in the current wait
   logic [3:0] sup_q, sup_d; // supply start counter
   status_s status_q, status_d;
   logic [4:0] adc_q, adc_d; // identification result
   logic [4:0] key_q, key_d; // latest remote key code
   events_s events_q, events_d;
   logic active_q, active_d;
   logic rst_q, rst_d; // set by reset, cleared on read
   switch_s sw_q, sw_d;
   logic adc_start_d;
   logic pwr_q;
   logic [4:0] code; // adc answer with open and short forced
   logic conv_done; // adc answer for our request
   logic is_key; // code lies in the remote key band
   logic is_test; // code is a test cable
   logic is_rc; // stored result is a remote-control accessory
   // bus side
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   logic [31:0] rdata_d;
   logic wr_fire, ar_take, rd_mode, wr_mode, wr_events, wr_switch;
   logic [31:0] rd_mux;
   logic rd_ok, wr_ok;

   localparam logic [10:0] SAMPLE_MS = 11'(`STANDBY_SAMPLE_MS);
   localparam logic [10:0] STUCK_MS = 11'(`STUCK_KEY_MS);

   // millisecond enable
   tick_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_q(tick)
   );

   // ----------------------------------------------------------------
   // code classification
   // ----------------------------------------------------------------
   // open and short override the converter; codes map one-to-one onto the ladder
   always_comb begin
      if (id_short_in) begin
         code = `ADC_SHORT_CODE;
      end else if (id_open_in) begin
         code = `ADC_OPEN_CODE;
      end else begin
         code = adc_code;
      end
      conv_done = adc_done && busy_q;
      is_key = (code >= `KEY_FIRST_CODE) && (code <= `KEY_LAST_CODE);
      is_test = (code == `TEST_USB_A_CODE) || (code == `TEST_USB_B_CODE) ||
         (code == `TEST_UART_A_CODE) || (code == `TEST_UART_B_CODE);
      is_rc = (adc_q == `RC_ACC_A_CODE) || (adc_q == `RC_ACC_B_CODE);
   end

   // ----------------------------------------------------------------
   // identification state machine and registers
   // ----------------------------------------------------------------
   // next state, register bits and adc requests
   always_comb begin
      state_d = state_q;
      busy_d = busy_q;
      ms_d = ms_q;
      sup_d = sup_q;
      status_d = status_q;
      adc_d = adc_q;
      key_d = key_q;
      events_d = events_q;
      active_d = active_q;
      rst_d = rst_q;
      sw_d = sw_q;
      adc_start_d = 1'b0;
      if (conv_done) begin
         busy_d = 1'b0;
      end
      // bus power is watched in every state except ST_CLEAR
      status_d.vbus_det = vbus_present;
      status_d.id_short_flag = id_short_in;
      if (ar_take && rd_mode) begin
         rst_d = 1'b0;
      end
      // write-one-to-clear first, so any set further down wins
      if (wr_events) begin
         events_d = events_q & ~events_s'(wdata_q[1:0]);
      end
      case (state_q)
         ST_SUPPLY: begin
            // let internal supplies settle
            sup_d = sup_q + 1'b1;
            if (sup_q == `SUPPLY_START_CYCLES) begin
               state_d = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            // whole-chip clear, then ready for accessories
            status_d = `STATUS_RESET;
            adc_d = `ADC_RESET;
            key_d = '0;
            active_d = 1'b0;
            sw_d = '0;
            ms_d = '0;
            state_d = ST_STANDBY;
         end
         ST_STANDBY: begin
            if (tick) begin
               ms_d = (ms_q == SAMPLE_MS - 11'h001) ? 11'h000 : ms_q + 11'h001;
            end
            if (vbus_present && !status_q.vbus_det) begin
               // bus power rising, or already there at supply-up
               state_d = ST_MEASURE;
            end else if (tick && (ms_q == SAMPLE_MS - 11'h001)) begin
               status_d.id_open_flag = id_open_in;
               if (!id_open_in) begin
                  state_d = ST_MEASURE;
               end
            end
         end
         ST_MEASURE: begin
            // adc and supply type run side by side
            if (!busy_q && !adc_done) begin
               adc_start_d = 1'b1;
               busy_d = 1'b1;
            end
            if (vbus_present) begin
               status_d.dpdm_short = dpdm_short_in;
               status_d.usb_chg = usb_chg_in;
            end else begin
               // supply-type results mean nothing without bus power
               status_d.dpdm_short = 1'b0;
               status_d.usb_chg = 1'b0;
            end
            if (conv_done) begin
               status_d.id_open_flag = id_open_in;
               adc_d = code;
               ms_d = '0;
               if (id_open_in && !vbus_present) begin
                  // nothing there after all
                  state_d = ST_STANDBY;
               end else if (is_key) begin
                  state_d = ST_STUCK;
               end else begin
                  events_d.flag_a = 1'b1;
                  active_d = 1'b1;
                  if (is_test) begin
                     sw_d.usb = (code == `TEST_USB_A_CODE) || (code == `TEST_USB_B_CODE);
                     sw_d.uart = (code == `TEST_UART_A_CODE) ||
                        (code == `TEST_UART_B_CODE);
                  end
                  state_d = ST_ACTIVE;
               end
            end
         end
         ST_STUCK, ST_KEY_HELD: begin
            // keep converting until the key code goes away
            if (!busy_q && !adc_done) begin
               adc_start_d = 1'b1;
               busy_d = 1'b1;
            end
            if (tick && (ms_q != STUCK_MS)) begin
               ms_d = ms_q + 11'h001;
            end
            if (conv_done && !is_key) begin
               state_d = ST_MEASURE;
            end else if ((state_q == ST_STUCK) && (ms_q == STUCK_MS)) begin
               events_d.flag_a = 1'b1;
               active_d = 1'b1;
               state_d = ST_KEY_HELD;
            end
         end
         ST_ACTIVE: begin
            if (status_q.vbus_det && !vbus_present && id_open_in) begin
               // powered accessory pulled with no id resistor
               events_d.detach = 1'b1;
               active_d = 1'b0;
               sw_d = '0;
               state_d = ST_STANDBY;
            end else if (id_open_in && !status_q.id_open_flag) begin
               // open flag rising means the accessory left
               status_d.id_open_flag = 1'b1;
               events_d.detach = 1'b1;
               active_d = 1'b0;
               sw_d = '0;
               adc_d = `ADC_OPEN_CODE;
               state_d = ST_STANDBY;
            end else if (wr_mode && !wdata_q[`MODE_ACTIVE_BIT]) begin
               active_d = 1'b0;
               state_d = ST_MEASURE;
            end else if (is_rc) begin
               // remote accessory: keep sampling for key presses
               if (!busy_q && !adc_done) begin
                  adc_start_d = 1'b1;
                  busy_d = 1'b1;
               end
               if (conv_done) begin
                  key_d = is_key ? code : 5'h00;
               end
            end
         end
         default: begin
            state_d = ST_SUPPLY;
         end
      endcase
      // host programming of switches, after the state machine so it wins
      if (wr_switch) begin
         sw_d = switch_s'(wdata_q[1:0]);
      end
   end

   // register the identification state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_SUPPLY;
         busy_q <= 1'b0;
         ms_q <= '0;
         sup_q <= '0;
         status_q <= `STATUS_RESET;
         adc_q <= `ADC_RESET;
         key_q <= '0;
         events_q <= '0;
         active_q <= 1'b0;
         rst_q <= 1'b1;
         sw_q <= '0;
         adc_start <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= busy_d;
         ms_q <= ms_d;
         sup_q <= sup_d;
         status_q <= status_d;
         adc_q <= adc_d;
         key_q <= key_d;
         events_q <= events_d;
         active_q <= active_d;
         rst_q <= rst_d;
         sw_q <= sw_d;
         adc_start <= adc_start_d;
      end
   end

   // power switch follows bus power, reset or not
   always_ff @(posedge aclk) begin
      pwr_q <= vbus_present;
   end

   assign power_switch_on = pwr_q;
   assign usb_switch_on = sw_q.usb;
   assign uart_switch_on = sw_q.uart;

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   // decode, read mux and handshakes
   always_comb begin
      wr_fire = aw_have_q && w_have_q && !bvalid;
      ar_take = arvalid && arready;
      wr_ok = (waddr_q[1:0] == 2'b00) && (waddr_q <= `REG_KEY);
      rd_ok = (araddr[1:0] == 2'b00) && (araddr <= `REG_KEY);
      wr_mode = wr_fire && wstrb_q[0] && (waddr_q == `REG_MODE);
      wr_events = wr_fire && wstrb_q[0] && (waddr_q == `REG_EVENTS);
      wr_switch = wr_fire && wstrb_q[0] && (waddr_q == `REG_SWITCH);
      rd_mode = (araddr == `REG_MODE);
      case (araddr)
         `REG_MODE: rd_mux = {30'h0, rst_q, active_q};
         `REG_STATUS: rd_mux = {27'h0, status_q};
         `REG_ADC: rd_mux = {27'h0, adc_q};
         `REG_EVENTS: rd_mux = {30'h0, events_q};
         `REG_SWITCH: rd_mux = {30'h0, sw_q};
         `REG_KEY: rd_mux = {27'h0, key_q};
         default: rd_mux = 32'h0;
      endcase
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      if (awvalid && awready) begin
         aw_have_d = 1'b1;
         waddr_d = awaddr;
      end
      if (wvalid && wready) begin
         w_have_d = 1'b1;
         wdata_d = wdata;
         wstrb_d = wstrb;
      end
      bvalid_d = bvalid && !bready;
      bresp_d = bresp;
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      awready_d = !aw_have_d;
      wready_d = !w_have_d;
      rvalid_d = rvalid && !rready;
      rdata_d = rdata;
      rresp_d = rresp;
      if (ar_take) begin
         rvalid_d = 1'b1;
         rdata_d = rd_mux;
         rresp_d = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      arready_d = !rvalid_d;
   end

   // register the bus side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready <= awready_d;
         wready <= wready_d;
         bvalid <= bvalid_d;
         bresp <= bresp_d;
         arready <= arready_d;
         rvalid <= rvalid_d;
         rdata <= rdata_d;
         rresp <= rresp_d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_conv_key;
      (state_q == ST_MEASURE) && conv_done && is_key && !(id_open_in && !vbus_present);
   endsequence

   sequence s_conv_test;
      (state_q == ST_MEASURE) && conv_done && is_test && !is_key;
   endsequence

   a_open_code: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_MEASURE) && conv_done && id_open_in && !id_short_in)
      |=> (adc_q == 5'h1f))
      else $error("floating id line not reported as all ones");

   a_short_code: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_MEASURE) && conv_done && id_short_in) |=> (adc_q == 5'h00))
      else $error("short id line not reported as zero");

   a_key_stuck_entry: assert property (@(posedge aclk) disable iff (!aresetn)
      s_conv_key |=> (state_q == ST_STUCK) && !$rose(events_q.flag_a))
      else $error("key code did not enter stuck key wait");

   a_stuck_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_STUCK) && (ms_q == 11'd1500) && !(conv_done && !is_key))
      |=> (state_q == ST_KEY_HELD) && events_q.flag_a && active_q)
      else $error("stuck key not reported after its wait");

   a_test_switch: assert property (@(posedge aclk) disable iff (!aresetn)
      s_conv_test |=> (usb_switch_on || uart_switch_on) && (state_q == ST_ACTIVE))
      else $error("test cable did not close a switch");

   a_power_follow: assert property (@(posedge aclk)
      ##1 (power_switch_on == $past(vbus_present)))
      else $error("power switch does not follow bus power");

   a_detach_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_ACTIVE) && id_open_in && !status_q.id_open_flag)
      |=> events_q.detach && (state_q == ST_STANDBY) ##1 (adc_start == 1'b0))
      else $error("detach not flagged on open id line");

   a_host_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_ACTIVE) && wr_mode && !wdata_q[0] && !id_open_in && !is_rc
         && !(status_q.vbus_det && !vbus_present))
      |=> (state_q == ST_MEASURE) ##[1:2] adc_start)
      else $error("clearing active did not restart identification");

   a_vbus_start: assert property (@(posedge aclk) disable iff (!aresetn)
      ((state_q == ST_STANDBY) && vbus_present && !status_q.vbus_det)
      |=> (state_q == ST_MEASURE))
      else $error("bus power rise did not start identification");

endmodule // acc_id_detect

// *** acc_model.sv ***
// Purpose: plugged-in accessory seen through the id adc
// Assumes: one conversion at a time, answer three cycles after the request
// Notes: code lines toggle outside the done cycle so stale data never looks valid
`timescale 1ns/1ps
module acc_model (
   input wire logic aclk,
   input wire logic adc_start,
   input wire logic [4:0] code,
   output logic adc_done,
   output logic [4:0] adc_code
);
   logic [1:0] wait_q = 2'h0; // cycles left until the answer
   initial begin
      adc_done = 1'h0;
      adc_code = 5'h00;
   end
   // conversion delay, then one done pulse with the resistor's code
   always @(posedge aclk) begin
      adc_done <= 1'h0;
      adc_code <= ~adc_code;
      if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      if (adc_start) wait_q <= 2'h3;
      if (wait_q == 2'h1) begin
         adc_done <= 1'h1;
         adc_code <= code;
      end
   end
endmodule // acc_model

// *** accessory_id_detection_test.sv ***
// Purpose: register-level bench of the accessory id block
// Assumes: tick shortened to 10 cycles
// Notes: results are read back over the register bus
`timescale 1ns/1ps
`include "acc_id_regs.svh"
module accessory_id_detection_test;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, vbus = 1'h1, id_open = 1'h1, id_short = 1'h0;
   logic dpdm = 1'h1, chg = 1'h0; // supply-type comparator levels
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [4:0] code = 5'h1f, acode;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, adc_start, adc_done, psw, usb, uart;
   int n_fail = 0, check_count = 0, cyc = 0;
   logic [4:0] codes [6] = '{5'h16, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1d};
   acc_id_detect #(.TICK_CYCLES(10)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .vbus_present(vbus),
      .id_open_in(id_open), .id_short_in(id_short), .dpdm_short_in(dpdm), .usb_chg_in(chg),
      .adc_start(adc_start), .adc_done(adc_done), .adc_code(acode), .power_switch_on(psw),
      .usb_switch_on(usb), .uart_switch_on(uart));
   acc_model i_acc (.aclk(aclk), .adc_start(adc_start), .code(code), .adc_done(adc_done),
      .adc_code(acode));
   // clock and hang guard
   initial begin
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask
   // poll the event register until the given flag is up, then clear both
   task automatic wait_ev(input int b);
      do rd(`REG_EVENTS); while (d[b] !== 1'h1);
      wr(`REG_EVENTS, 32'h3);
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      chk(psw, 1'h1);
      aresetn <= 1'h1;
      wait_ev(0);
      rc(`REG_STATUS, 32'h0d);
      rc(`REG_MODE, 32'h3);
      rc(`REG_MODE, 32'h1);
      dpdm <= 1'h0;
      chg <= 1'h1;
      wr(`REG_MODE, 32'h0);
      wait_ev(0);
      rc(`REG_STATUS, 32'h15);
      rd(8'h18);
      chk(rs, `RESP_SLVERR);
      vbus <= 1'h0;
      wait_ev(1);
      chk(psw, 1'h0);
      for (int i = 0; i < 6; i++) begin
         code <= codes[i];
         id_open <= 1'h0;
         wait_ev(0);
         rc(`REG_ADC, codes[i]);
         chk({usb, uart}, {codes[i][4:1] == 4'h8, codes[i][4:1] == 4'h9});
         wr(`REG_MODE, 32'h0);
         wait_ev(0);
         id_open <= 1'h1;
         wait_ev(1);
         rc(`REG_ADC, 32'h1f);
      end
      code <= 5'h15;
      id_short <= 1'h1;
      id_open <= 1'h0;
      wait_ev(0);
      rc(`REG_ADC, 32'h00);
      rc(`REG_STATUS, 32'h02);
      id_short <= 1'h1;
      id_open <= 1'h1;
      wait_ev(1);
      id_short <= 1'h0;
      code <= 5'h03;
      id_open <= 1'h0;
      wait_ev(0);
      rc(`REG_ADC, 32'h03);
      code <= 5'h1e;
      wait_ev(0);
      rc(`REG_ADC, 32'h1e);
      // remote accessory attached: a key press shows in the key register
      code <= 5'h07;
      repeat (8) @(posedge aclk);
      rc(`REG_KEY, 32'h07);
      code <= 5'h1e;
      repeat (8) @(posedge aclk);
      rc(`REG_KEY, 32'h00);
      conclude();
   end
endmodule // accessory_id_detection_test
